/* File: rtl/lrs_regs.sv */
// Lock, soft reset, readback and temperature register logic
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_regs (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic spi_mode_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  input wire logic status_tx_in,
  input wire logic [1:0] status_tx_errs_in,
  input wire logic readback_mismatch_in,
  input wire logic temp_valid_in,
  input wire logic [7:0] temp_value_in,
  input wire logic [7:0] supply_errs_in,
  input wire logic selftest_req_in,
  input wire logic fault_inject_in,
  output logic resp_valid_out,
  output logic [7:0] resp_data_out,
  output logic resp_suppress_out,
  output logic resp_error_code_out,
  output logic ack_suppress_out,
  output logic soft_reset_out,
  output logic selftest_start_out,
  output logic selftest_enable_out,
  output logic [7:0] lock_reg_out,
  output logic [7:0] user_cfg_out,
  output logic readback_err_out,
  output logic user_check_err_out,
  output logic [7:0] supply_status_out
);
  // ****************************************
  // Request decode
  // ****************************************
  logic [7:0] lock_reg;
  logic [7:0] user_cfg;
  logic [7:0] die_temp;
  logic readback_err;
  logic user_check_err;
  logic [7:0] supply_flags;
  logic [15:0] supply_timer;
  logic error_reply_due;
  logic [7:0] stored_code;
  logic [7:0] live_code;
  logic [7:0] next_code;
  logic [7:0] next_lock;
  logic [7:0] next_user_cfg;
  logic locked;
  logic is_read;
  logic is_write;
  logic wr_lock;
  logic key_final;
  logic timer_zero;
  lrs_pkg::lrs_key_state_t key_state;

  assign locked = lock_reg[`LRS_BIT_INIT_DONE_LOCK];
  assign is_read = req_valid_in && !req_write_in;
  assign is_write = req_valid_in && req_write_in;
  assign wr_lock = is_write && (req_addr_in == `LRS_OFF_LOCK_CONTROL);
  assign timer_zero = (supply_timer == 16'h0000);
  assign key_final = wr_lock && (key_state == lrs_pkg::LRS_KEY_GOT_TWO) &&
    (req_wdata_in[1:0] == `LRS_KEY_STEP_THREE);

  always_comb begin
    next_lock = lock_reg;
    if (wr_lock) begin
      if (locked) begin
        next_lock = {lock_reg[7:2], req_wdata_in[1:0]};
      end else begin
        next_lock = req_wdata_in & `LRS_LOCK_WRITABLE_MASK;
        next_lock[`LRS_BIT_INIT_DONE_LOCK] =
          req_wdata_in[`LRS_BIT_INIT_DONE_LOCK];
      end
      if (locked) begin
        next_lock[`LRS_BIT_INIT_DONE_LOCK] = 1'b1;
      end
    end else if (is_read) begin
      next_lock = {lock_reg[7:2], 2'h0};
    end
  end

  always_comb begin
    next_user_cfg = user_cfg;
    if (is_write && !locked &&
        (req_addr_in == `LRS_OFF_USER_CONFIG)) begin
      next_user_cfg = req_wdata_in;
    end
  end

  // ****************************************
  // Lock and configuration storage
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lock_reg <= `LRS_RESET_LOCK;
    end else begin
      lock_reg <= next_lock;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      user_cfg <= `LRS_RESET_USER_CONFIG;
    end else begin
      user_cfg <= next_user_cfg;
    end
  end

  // ****************************************
  // Soft reset key sequence
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      key_state <= lrs_pkg::LRS_KEY_IDLE;
    end else if (is_read) begin
      key_state <= lrs_pkg::LRS_KEY_IDLE;
    end else if (wr_lock) begin
      unique case (key_state)
        lrs_pkg::LRS_KEY_IDLE: begin
          if (req_wdata_in[1:0] == `LRS_KEY_STEP_ONE) begin
            key_state <= lrs_pkg::LRS_KEY_GOT_ONE;
          end
        end
        lrs_pkg::LRS_KEY_GOT_ONE: begin
          if (req_wdata_in[1:0] == `LRS_KEY_STEP_TWO) begin
            key_state <= lrs_pkg::LRS_KEY_GOT_TWO;
          end else if (req_wdata_in[1:0] == `LRS_KEY_STEP_ONE) begin
            key_state <= lrs_pkg::LRS_KEY_GOT_ONE;
          end else begin
            key_state <= lrs_pkg::LRS_KEY_IDLE;
          end
        end
        lrs_pkg::LRS_KEY_GOT_TWO: begin
          if (req_wdata_in[1:0] == `LRS_KEY_STEP_ONE) begin
            key_state <= lrs_pkg::LRS_KEY_GOT_ONE;
          end else begin
            key_state <= lrs_pkg::LRS_KEY_IDLE;
          end
        end
        default: begin
          key_state <= lrs_pkg::LRS_KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= key_final;
    end
  end

  // ****************************************
  // Responses
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_data_out <= 8'h00;
      ack_suppress_out <= 1'b0;
    end else begin
      resp_valid_out <= req_valid_in && !key_final;
      ack_suppress_out <= key_final && !spi_mode_in;
      if (is_write) begin
        if (req_addr_in == `LRS_OFF_LOCK_CONTROL) begin
          resp_data_out <= next_lock;
        end else if (req_addr_in == `LRS_OFF_USER_CONFIG) begin
          resp_data_out <= next_user_cfg;
        end else begin
          resp_data_out <= 8'h00;
        end
      end else if (is_read) begin
        unique case (req_addr_in)
          `LRS_OFF_DEVICE_STATUS_THREE:
            resp_data_out <= {readback_err, 7'h00};
          `LRS_OFF_MEMORY_STATUS:
            resp_data_out <= {2'h0, user_check_err, 5'h00};
          `LRS_OFF_SUPPLY_STATUS: resp_data_out <= supply_flags;
          `LRS_OFF_DIE_TEMPERATURE: resp_data_out <= die_temp;
          `LRS_OFF_LOCK_CONTROL:
            resp_data_out <= {lock_reg[7:2], 2'h0};
          `LRS_OFF_USER_CONFIG: resp_data_out <= user_cfg;
          default: resp_data_out <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Status flags and temperature
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      readback_err <= 1'b0;
    end else if (spi_mode_in && readback_mismatch_in) begin
      readback_err <= 1'b1;
    end else if ((is_read &&
                 req_addr_in == `LRS_OFF_DEVICE_STATUS_THREE) ||
                 (spi_mode_in && status_tx_in && status_tx_errs_in[0])) begin
      readback_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      die_temp <= `LRS_RESET_TEMPERATURE;
    end else if (temp_valid_in) begin
      die_temp <= temp_value_in;
    end
  end

  lrs_check_code u_code (
    .lock_bits_in(lock_reg),
    .user_cfg_in(user_cfg ^ {7'h00, fault_inject_in}),
    .code_out(live_code)
  );

  // Code of the values the next edge stores, lock bit included
  lrs_check_code u_next_code (
    .lock_bits_in(next_lock),
    .user_cfg_in(next_user_cfg),
    .code_out(next_code)
  );

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stored_code <= 8'h00;
    end else if (!locked) begin
      stored_code <= next_code;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      user_check_err <= 1'b0;
    end else if (locked && (live_code != stored_code)) begin
      user_check_err <= 1'b1;
    end else if ((is_read && req_addr_in == `LRS_OFF_MEMORY_STATUS) ||
                 (spi_mode_in && status_tx_in && status_tx_errs_in[1])) begin
      user_check_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      selftest_start_out <= 1'b0;
      selftest_enable_out <= 1'b0;
    end else begin
      selftest_enable_out <= !locked;
      selftest_start_out <= selftest_req_in && !locked;
    end
  end

  // ****************************************
  // Supply monitor timer and reporting
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      supply_timer <= 16'h0000;
    end else if (supply_errs_in != 8'h00) begin
      supply_timer <= 16'(`LRS_SUPPLY_RCV_CYC);
    end else if (!timer_zero) begin
      supply_timer <= supply_timer - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      supply_flags <= 8'h00;
    end else begin
      if (timer_zero && ((is_read &&
          req_addr_in == `LRS_OFF_SUPPLY_STATUS) ||
          (spi_mode_in && !lock_reg[`LRS_BIT_SUPPLY_REPORT_DIS] &&
          status_tx_in))) begin
        supply_flags <= supply_errs_in;
      end else if (spi_mode_in && lock_reg[`LRS_BIT_SUPPLY_REPORT_DIS] &&
                   timer_zero) begin
        supply_flags <= supply_errs_in;
      end else begin
        supply_flags <= supply_flags | supply_errs_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      error_reply_due <= 1'b0;
      resp_error_code_out <= 1'b0;
    end else begin
      if (supply_errs_in != 8'h00 && spi_mode_in &&
          !lock_reg[`LRS_BIT_SUPPLY_REPORT_DIS]) begin
        error_reply_due <= 1'b1;
      end else if (req_valid_in && timer_zero) begin
        error_reply_due <= 1'b0;
      end
      resp_error_code_out <= error_reply_due && timer_zero &&
        req_valid_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      resp_suppress_out <= 1'b0;
    end else begin
      resp_suppress_out <= (supply_errs_in != 8'h00) ||
        !timer_zero;
    end
  end

  // ****************************************
  // Observation outputs
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lock_reg_out <= 8'h00;
      user_cfg_out <= 8'h00;
      readback_err_out <= 1'b0;
      user_check_err_out <= 1'b0;
      supply_status_out <= 8'h00;
    end else begin
      lock_reg_out <= lock_reg;
      user_cfg_out <= user_cfg;
      readback_err_out <= readback_err;
      user_check_err_out <= user_check_err;
      supply_status_out <= supply_flags;
    end
  end
endmodule

/* File: rtl/lrs_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LRS_MAP_SVH
`define LRS_MAP_SVH
`define LRS_OFF_SUPPLY_STATUS 8'h02
`define LRS_OFF_MEMORY_STATUS 8'h03
`define LRS_OFF_DEVICE_STATUS_THREE 8'h04
`define LRS_OFF_DIE_TEMPERATURE 8'h0e
`define LRS_OFF_LOCK_CONTROL 8'h10
`define LRS_OFF_USER_CONFIG 8'h11
`define LRS_BIT_READBACK_ERR 7
`define LRS_BIT_USER_CHECK_ERR 5
`define LRS_BIT_INIT_DONE_LOCK 7
`define LRS_BIT_SUPPLY_REPORT_DIS 3
`define LRS_LOCK_WRITABLE_MASK 8'h8b
`define LRS_KEY_STEP_ONE 2'h0
`define LRS_KEY_STEP_TWO 2'h3
`define LRS_KEY_STEP_THREE 2'h2
`define LRS_RESET_LOCK 8'h00
`define LRS_RESET_TEMPERATURE 8'h00
`define LRS_RESET_USER_CONFIG 8'h00
`define LRS_SUPPLY_RCV_NS 1000
`define LRS_CLK_PERIOD_NS 5
`define LRS_SUPPLY_RCV_CYC (`LRS_SUPPLY_RCV_NS / `LRS_CLK_PERIOD_NS)
`endif

/* File: rtl/lrs_pkg.sv */
// Types shared by the lock, reset and status register block
package lrs_pkg;
  typedef enum logic [1:0] {
    LRS_KEY_IDLE,
    LRS_KEY_GOT_ONE,
    LRS_KEY_GOT_TWO
  } lrs_key_state_t;
endpackage

/* File: rtl/lrs_check_code.sv */
// Error detection code over lock bits 7:2 and the user configuration bits, lock key bits 1:0 excluded
`timescale 1ns/1ps
module lrs_check_code (
  input wire logic [7:0] lock_bits_in,
  input wire logic [7:0] user_cfg_in,
  output logic [7:0] code_out
);
  always_comb begin
    code_out = {lock_bits_in[7:2], 2'h0} ^ {user_cfg_in[6:0], user_cfg_in[7]};
    code_out = code_out ^ 8'h5a;
  end
endmodule

/* File: dv/lrs_regs_props.sv */
// Checker for the lock, reset and status register block
`timescale 1ns/1ps
module lrs_regs_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic spi_mode_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_addr_in,
  input wire logic readback_mismatch_in,
  input wire logic fault_inject_in,
  input wire logic resp_valid_out,
  input wire logic [7:0] resp_data_out,
  input wire logic resp_error_code_out,
  input wire logic ack_suppress_out,
  input wire logic soft_reset_out,
  input wire logic selftest_start_out,
  input wire logic selftest_enable_out,
  input wire logic [7:0] lock_reg_out,
  input wire logic [7:0] user_cfg_out,
  input wire logic readback_err_out,
  input wire logic user_check_err_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ****
  // Locked and clear of any soft reset
  // ****
  logic [2:0] sr_hist;
  logic held;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) sr_hist <= 3'h0;
    else sr_hist <= {sr_hist[1:0], soft_reset_out};
  end
  assign held = lock_reg_out[7] && !soft_reset_out && sr_hist == 3'h0;
  property p_lock_sticky; held |=> lock_reg_out[7]; endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock bit dropped");
  property p_lock_fields;
    held |=> lock_reg_out[7:2] == $past(lock_reg_out[7:2]);
  endproperty
  a_lock_fields: assert property (p_lock_fields)
    else $error("locked lock field changed");
  property p_cfg_frozen; held |=> $stable(user_cfg_out); endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("locked config changed");
  property p_no_selftest;
    lock_reg_out[7] && $past(lock_reg_out[7])
      |-> !selftest_start_out && !selftest_enable_out;
  endproperty
  a_no_selftest: assert property (p_no_selftest)
    else $error("self-test while locked");
  property p_reset_silent; soft_reset_out |-> !resp_valid_out; endproperty
  a_reset_silent: assert property (p_reset_silent)
    else $error("reply with soft reset");
  property p_ack_i2c;
    ack_suppress_out |-> soft_reset_out && !spi_mode_in;
  endproperty
  a_ack_i2c: assert property (p_ack_i2c)
    else $error("stray no-ack");
  property p_key_read;
    req_valid_in && !req_write_in && req_addr_in == 8'h10
      |=> resp_valid_out |-> resp_data_out[1:0] == 2'h0;
  endproperty
  a_key_read: assert property (p_key_read)
    else $error("key bits read nonzero");
  property p_temp_write;
    req_valid_in && req_write_in && req_addr_in == 8'h0e
      |=> resp_valid_out |-> resp_data_out == 8'h00;
  endproperty
  a_temp_write: assert property (p_temp_write)
    else $error("temperature write answered nonzero");
  property p_rb_set;
    readback_mismatch_in && spi_mode_in |-> ##[1:2] readback_err_out;
  endproperty
  a_rb_set: assert property (p_rb_set)
    else $error("readback flag not set");
  property p_rb_clear;
    req_valid_in && !req_write_in && req_addr_in == 8'h04
      && !readback_mismatch_in ##1 !readback_mismatch_in
      |=> !readback_err_out;
  endproperty
  a_rb_clear: assert property (p_rb_clear)
    else $error("readback flag not cleared");
  property p_check_err;
    lock_reg_out[7] && fault_inject_in |-> ##[1:16] user_check_err_out;
  endproperty
  a_check_err: assert property (p_check_err)
    else $error("check code fault missed");
  c_reset: cover property (soft_reset_out);
  c_err_code: cover property (resp_valid_out && resp_error_code_out);
  c_check: cover property (user_check_err_out);
  c_rb: cover property (readback_err_out);
endmodule

/* File: dv/lrs_host.sv */
// Host model issuing register requests
`timescale 1ns/1ps
module lrs_host (
  input wire logic clk_in,
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_data_in,
  output logic req_valid_out,
  output logic req_write_out,
  output logic [7:0] req_addr_out,
  output logic [7:0] req_wdata_out
);
  initial begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_addr_out = 8'h00;
    req_wdata_out = 8'h00;
  end
  // One request, then up to three cycles for its answer
  task automatic access(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] r, output logic got);
    int n;
    @(posedge clk_in);
    #1;
    req_valid_out = 1'b1;
    req_write_out = w;
    req_addr_out = a;
    req_wdata_out = d;
    @(posedge clk_in);
    #1;
    req_valid_out = 1'b0;
    req_addr_out = ~a;
    req_wdata_out = ~d;
    got = 1'b0;
    r = 8'h00;
    for (n = 0; n < 3; n++) begin
      if (!got && resp_valid_in === 1'b1) begin
        got = 1'b1;
        r = resp_data_in;
      end
      @(posedge clk_in);
      #1;
    end
  endtask
endmodule

/* File: dv/lock_reset_status_regs_test.sv */
// Self-checking bench for the lock, reset and status register block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module lock_reset_status_regs_test;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, spi_mode_in = 1'b1;
  logic status_tx_in = 1'b0, readback_mismatch_in = 1'b0;
  logic temp_valid_in = 1'b0, selftest_req_in = 1'b0;
  logic fault_inject_in = 1'b0;
  logic [1:0] status_tx_errs_in = 2'h0;
  logic [7:0] temp_value_in = 8'h00, supply_errs_in = 8'h00;
  logic req_valid_in, req_write_in, resp_valid_out, resp_suppress_out;
  logic [7:0] req_addr_in, req_wdata_in, resp_data_out, lock_reg_out;
  logic resp_error_code_out, ack_suppress_out, soft_reset_out;
  logic selftest_start_out, selftest_enable_out, readback_err_out;
  logic user_check_err_out;
  logic [7:0] user_cfg_out, supply_status_out, u, t, r;
  logic g;
  int mismatches = 0, checks = 0, sr_cnt = 0, ack_cnt = 0, ec_cnt = 0, n;
  lrs_regs i_lrs_regs (.*);
  lrs_host i_lrs_host (.clk_in(clk_sys_in), .resp_valid_in(resp_valid_out),
    .resp_data_in(resp_data_out), .req_valid_out(req_valid_in),
    .req_write_out(req_write_in), .req_addr_out(req_addr_in),
    .req_wdata_out(req_wdata_in));
  always #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (soft_reset_out === 1'b1) sr_cnt++;
    if (ack_suppress_out === 1'b1) ack_cnt++;
    if (resp_error_code_out === 1'b1 && resp_valid_out === 1'b1) ec_cnt++;
  end
  // ****
  // Shared tasks
  // ****
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [7:0] d, input logic [7:0] e, input logic eg);
    i_lrs_host.access(w, a, d, r, g);
    `CHK(g, eg)
    if (eg && g) `CHK(r, e)
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic supply_run(input logic dis);
    tick(1);
    supply_errs_in = 8'h01 << ($urandom % 8);
    tick(4);
    `CHK(resp_suppress_out, 1'b1)
    supply_errs_in = 8'h00;
    for (n = 0; n < 400 && resp_suppress_out !== 1'b0; n++) tick(1);
    if (n == 400) begin
      mismatches++;
      close_out();
    end
    `CHK(n >= 195, 1'b1)
    if (!dis) begin
      `CHK(supply_status_out !== 8'h00, 1'b1)
      i_lrs_host.access(1'b0, 8'h02, 8'h00, r, g);
      `CHK(ec_cnt, 1)
      acc(1'b0, 8'h02, 8'h00, 8'h00, 1'b1);
    end else begin
      tick(1);
      `CHK(supply_status_out, 8'h00)
      acc(1'b0, 8'h02, 8'h00, 8'h00, 1'b1);
    end
    `CHK(ec_cnt, 1)
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(33));
    tick(10);
    rst_in = 1'b0;
    acc(1'b0, 8'h0e, 8'h00, 8'h00, 1'b1);
    acc(1'b0, 8'h10, 8'h00, 8'h00, 1'b1);
    t = 8'($urandom);
    temp_valid_in = 1'b1;
    temp_value_in = t;
    tick(1);
    temp_valid_in = 1'b0;
    acc(1'b1, 8'h0e, ~t, 8'h00, 1'b1);
    acc(1'b0, 8'h0e, 8'h00, t, 1'b1);
    readback_mismatch_in = 1'b1;
    tick(1);
    readback_mismatch_in = 1'b0;
    tick(2);
    acc(1'b0, 8'h04, 8'h00, 8'h80, 1'b1);
    acc(1'b0, 8'h04, 8'h00, 8'h00, 1'b1);
    readback_mismatch_in = 1'b1;
    tick(3);
    readback_mismatch_in = 1'b0;
    status_tx_in = 1'b1;
    status_tx_errs_in = 2'h1;
    tick(1);
    status_tx_in = 1'b0;
    tick(3);
    `CHK(readback_err_out, 1'b0)
    supply_run(1'b0);
    acc(1'b1, 8'h10, 8'h08, 8'h08, 1'b1);
    supply_run(1'b1);
    u = 8'($urandom);
    acc(1'b1, 8'h11, u, u, 1'b1);
    acc(1'b1, 8'h10, 8'h88, 8'h88, 1'b1);
    selftest_req_in = 1'b1;
    tick(1);
    `CHK(selftest_start_out, 1'b0)
    selftest_req_in = 1'b0;
    tick(2);
    `CHK(selftest_enable_out, 1'b0)
    acc(1'b1, 8'h11, ~u, u, 1'b1);
    acc(1'b1, 8'h10, 8'h03, 8'h8b, 1'b1);
    acc(1'b1, 8'h10, 8'h00, 8'h88, 1'b1);
    `CHK(user_cfg_out, u)
    `CHK(user_check_err_out, 1'b0)
    fault_inject_in = 1'b1;
    tick(20);
    `CHK(user_check_err_out, 1'b1)
    fault_inject_in = 1'b0;
    acc(1'b1, 8'h10, 8'h03, 8'h8b, 1'b1);
    acc(1'b0, 8'h10, 8'h00, 8'h88, 1'b1);
    acc(1'b1, 8'h10, 8'h02, 8'h8a, 1'b1);
    acc(1'b1, 8'h10, 8'h00, 8'h88, 1'b1);
    acc(1'b1, 8'h10, 8'h01, 8'h89, 1'b1);
    acc(1'b1, 8'h10, 8'h03, 8'h8b, 1'b1);
    acc(1'b1, 8'h10, 8'h02, 8'h8a, 1'b1);
    `CHK(sr_cnt, 0)
    spi_mode_in = 1'b0;
    acc(1'b1, 8'h10, 8'h00, 8'h88, 1'b1);
    acc(1'b1, 8'h10, 8'h03, 8'h8b, 1'b1);
    acc(1'b1, 8'h10, 8'h02, 8'h00, 1'b0);
    `CHK(sr_cnt, 1)
    `CHK(ack_cnt, 1)
    close_out();
  end
endmodule
bind lrs_regs lrs_regs_props i_lrs_regs_props (.*);
